// file: bench/bus_node_model.sv
// Far-side bus nodes: node 0 sends long or short dominant bits
`timescale 1ns/1ps
module bus_node_model (
  input wire clk_i,
  input wire load_i,
  input wire [3:0] bits_i,
  input wire [8:0] dom_len_i,
  output wire [5:0] node_dominant_n_o,
  output wire busy_o
);
  reg [3:0] left_reg = 4'h0;
  reg [8:0] t_reg = 9'h000;
  // Moves just after the rising edge; the bench drives load at the falling edge without a race
  always @(posedge clk_i) begin
    if (load_i) begin
      left_reg <= bits_i;
      t_reg <= 9'h000;
    end else if (left_reg != 4'h0) begin
      t_reg <= t_reg + 9'h001;
      if (t_reg == dom_len_i + 9'h010) begin
        left_reg <= left_reg - 4'h1;
        t_reg <= 9'h000;
      end
    end
  end
  // Others stay recessive so node 0 alone must win the wired-AND
  assign node_dominant_n_o = (busy_o && t_reg < dom_len_i) ? 6'h3E : 6'h3F;
  assign busy_o = left_reg != 4'h0;
endmodule

// file: bench/fault_flags_monitor.sv
// Checker for the fault flag block ports
`timescale 1ns/1ps
`include "fault_flags_defs.vh"
module fault_flags_monitor (
  input wire clk_i,
  input wire rstn_i,
  input wire [5:0] node_dominant_n_i,
  input wire [5:0] fault_detect_i,
  input wire serial_status_i,
  input wire [7:0] reg_addr_i,
  input wire reg_wr_i,
  input wire [7:0] reg_wdata_i,
  input wire [7:0] reg_rdata_o,
  input wire bus_level_o,
  input wire bus_idle_o,
  input wire [7:0] spi_fault_interrupt_status_o,
  input wire [7:0] bus_fault_interrupt_status_o,
  input wire [7:0] global_interrupt_o
);
  wire [7:0] bf = bus_fault_interrupt_status_o;
  wire [7:0] sf = spi_fault_interrupt_status_o;
  wire [7:0] gi = global_interrupt_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  a_rsvd_read_zero: assert property (bf[7:6] == 2'h0 && sf[6:0] == 7'h00)
    else $error("reserved flag bit set");
  a_global_spi_or: assert property (gi[4] == sf[7])
    else $error("global serial summary wrong");
  a_global_bus_or: assert property (gi[3] == (|bf))
    else $error("global bus summary wrong");
  a_idle_is_high: assert property (bus_idle_o == (bus_level_o == 1'b1))
    else $error("idle does not follow recessive");
  a_dominant_wins: assert property ((node_dominant_n_i != 6'h3F) [*5] |-> !bus_level_o)
    else $error("dominant node lost");
  a_flags_sticky: assert property (!(reg_wr_i && reg_addr_i == 8'h54) |=>
    (bf & $past(bf)) == $past(bf))
    else $error("bus flag dropped without clear");
  a_zero_write_keeps: assert property (reg_wr_i && reg_wdata_i == 8'h00 |=> sf[7] >= $past(sf[7]))
    else $error("zero write cleared flag");
  a_serial_sets: assert property ($rose(serial_status_i) |-> ##[2:4] sf[7])
    else $error("serial flag late");
  a_clear_works: assert property (reg_wr_i && reg_addr_i == 8'h54 && reg_wdata_i[5:0] == 6'h3F &&
    fault_detect_i == 6'h00 && $past(fault_detect_i) == 6'h00 &&
    $past(fault_detect_i, 2) == 6'h00 && $past(fault_detect_i, 3) == 6'h00 |=> bf == 8'h00)
    else $error("bus flag clear failed");
endmodule

// file: bench/tb.sv
// Bench for the fault flag block
`timescale 1ns/1ps
module tb;
  reg clk_i = 1'b0, rstn_i = 1'b0, serial_status_i = 1'b0, reg_wr_i = 1'b0, load = 1'b0;
  reg [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00;
  reg [5:0] fault_detect_i = 6'h00;
  reg [3:0] bits = 4'h0;
  reg [8:0] dlen = 9'h000;
  wire [7:0] reg_rdata_o, sf, bf, gi;
  wire [5:0] nd;
  wire bus_level_o, bus_idle_o, busy;
  integer miscompares = 0, tests_run = 0, cyc = 0, i;
  bus_node_model i_node (.clk_i(clk_i), .load_i(load), .bits_i(bits), .dom_len_i(dlen),
    .node_dominant_n_o(nd), .busy_o(busy));
  bus_fault_interrupt_flags i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .node_dominant_n_i(nd),
    .fault_detect_i(fault_detect_i), .serial_status_i(serial_status_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .bus_level_o(bus_level_o), .bus_idle_o(bus_idle_o), .spi_fault_interrupt_status_o(sf),
    .bus_fault_interrupt_status_o(bf), .global_interrupt_o(gi));
  always #4 clk_i = ~clk_i;
  // Ceiling well above the longest sequence so a hang ends the run
  always @(posedge clk_i) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      miscompares = miscompares + 1;
      give_verdict;
    end
  end
  task chk(input string nm, input [7:0] s, input [7:0] e);
    tests_run = tests_run + 1;
    if (s !== e) begin
      miscompares = miscompares + 1;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(negedge clk_i) {reg_addr_i, reg_wdata_i, reg_wr_i} = {a, d, 1'b1};
    @(negedge clk_i) reg_wr_i = 1'b0;
  endtask
  // Read data is registered, so it is looked at one cycle after the address
  task rd(input [7:0] a, input [7:0] e);
    @(negedge clk_i) reg_addr_i = a;
    @(negedge clk_i) chk("rdata", reg_rdata_o, e);
  endtask
  // Raise a fault, send n bits of given dominant length, then drop it
  task send(input [5:0] f, input [3:0] n, input [8:0] len);
    @(negedge clk_i) fault_detect_i = f;
    repeat (3) @(negedge clk_i);
    {bits, dlen, load} = {n, len, 1'b1};
    @(negedge clk_i) load = 1'b0;
    repeat (8) @(negedge clk_i);
    chk("level", bus_level_o, 8'h00);
    chk("idle", bus_idle_o, 8'h00);
    for (i = 0; i < 20000 && busy; i = i + 1) @(negedge clk_i);
    fault_detect_i = 6'h00;
    repeat (5) @(negedge clk_i);
    chk("level", bus_level_o, 8'h01);
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge clk_i);
    rstn_i = 1'b1;
    repeat (4) @(negedge clk_i);
    rd(8'h53, 8'h00); rd(8'h54, 8'h00); rd(8'h50, 8'h00);
    rd(8'h60, 8'h00); chk("idle", bus_idle_o, 1'b1);
    $display("test reset done");
    serial_status_i = 1'b1;
    repeat (6) @(negedge clk_i);
    rd(8'h53, 8'h80); rd(8'h50, 8'h90);
    wr(8'h53, 8'h00); rd(8'h53, 8'h80);
    wr(8'h53, 8'h80); rd(8'h53, 8'h00);
    $display("test serial flag done");
    for (int k = 0; k < 6; k = k + 1) begin
      send(6'h01 << k, 4'h5, 9'd200);
      rd(8'h54, 8'h01 << k); rd(8'h50, 8'h88);
      wr(8'h54, 8'hFF); rd(8'h54, 8'h00);
    end
    $display("test bus flags done");
    send(6'h01, 4'h5, 9'd100); rd(8'h54, 8'h00);
    send(6'h01, 4'h3, 9'd200); rd(8'h54, 8'h00);
    $display("test qualify done");
    give_verdict;
  end
endmodule
bind bus_fault_interrupt_flags fault_flags_monitor i_mon (.*);

// file: hw/bus_fault_interrupt_flags.v
// Fault status registers: serial port fault, bus fault flags and global summary
// Structure
// The host reaches the two status registers and the global summary through a simple
// address, write strobe and write data interface that the serial front end drives.
// Read data is registered, so it shows the addressed register one cycle later.
// Writes to the global summary or to unmapped addresses change nothing.
//
// Limitations
// A qualified fault keeps setting its flag for as long as the detector stays high on
// a recessive bus, so a clear only sticks once the fault itself has gone away.
// The dominant length counter saturates, so very long dominant bits still count as long.
// The serial fault flag sets on the rising edge of the status level only; a level that
// stays high after a clear does not set the flag again.
//
// Trade-offs
// Every asynchronous input passes two flops, which adds two cycles of latency to each
// flag; this is small next to the length of a qualifying dominant bit.
// Set wins over clear so that no fault event can be lost in a clear cycle.
`timescale 1ns/1ps
`include "fault_flags_defs.vh"
module bus_fault_interrupt_flags (
  input wire clk_i,
  input wire rstn_i,
  input wire [`BUS_FLAG_COUNT-1:0] node_dominant_n_i,
  input wire [`BUS_FLAG_COUNT-1:0] fault_detect_i,
  input wire serial_status_i,
  input wire [7:0] reg_addr_i,
  input wire reg_wr_i,
  input wire [7:0] reg_wdata_i,
  output reg [7:0] reg_rdata_o,
  output reg bus_level_o,
  output reg bus_idle_o,
  output wire [7:0] spi_fault_interrupt_status_o,
  output wire [7:0] bus_fault_interrupt_status_o,
  output wire [7:0] global_interrupt_o
);
  reg rst_meta_reg;
  reg rst_sync_reg;
  reg [`BUS_FLAG_COUNT-1:0] fault_meta_reg;
  reg [`BUS_FLAG_COUNT-1:0] fault_sync_reg;
  reg [`BUS_FLAG_COUNT-1:0] dom_meta_reg;
  reg [`BUS_FLAG_COUNT-1:0] dom_sync_reg;
  reg serial_meta_reg;
  reg serial_sync_reg;
  reg serial_prev_reg;
  reg serial_port_fault_flag;
  reg [`BUS_FLAG_COUNT-1:0] bus_flags_reg;
  reg [`DOM_CNT_W-1:0] dom_cnt_reg;
  reg long_dom_reg;
  reg bus_prev_reg;
  wire wired_bus;
  wire long_edge;
  wire serial_set;
  wire spi_wr_clear;
  wire bus_wr_clear;
  wire [`BUS_FLAG_COUNT-1:0] fault_event;
  wire spi_or;
  wire bus_or;

  // Reset release through two flops; assertion stays asynchronous
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // Detector and bus pins are asynchronous to the core clock, so two flops each
  always @(posedge clk_i or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      fault_meta_reg <= 6'h00;
      fault_sync_reg <= 6'h00;
      dom_meta_reg <= 6'h3F;
      dom_sync_reg <= 6'h3F;
      serial_meta_reg <= 1'b0;
      serial_sync_reg <= 1'b0;
      serial_prev_reg <= 1'b0;
    end else begin
      fault_meta_reg <= fault_detect_i;
      fault_sync_reg <= fault_meta_reg;
      dom_meta_reg <= node_dominant_n_i;
      dom_sync_reg <= dom_meta_reg;
      serial_meta_reg <= serial_status_i;
      serial_sync_reg <= serial_meta_reg;
      serial_prev_reg <= serial_sync_reg;
    end
  end

  // Wired-AND: any node driving low makes the bus dominant
  assign wired_bus = &dom_sync_reg;

  // Bus level and idle indication; recessive counts as high and idle
  always @(posedge clk_i or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      bus_level_o <= 1'b1;
      bus_idle_o <= 1'b1;
      bus_prev_reg <= 1'b1;
    end else begin
      bus_level_o <= wired_bus;
      bus_idle_o <= (wired_bus == `RECESSIVE_LEVEL);
      bus_prev_reg <= wired_bus;
    end
  end

  // Measure each dominant bit; saturating counter marks a long one
  // The mark is taken while the bit is still dominant, so it is ready on the
  // very edge at which the bus returns to recessive.
  always @(posedge clk_i or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      dom_cnt_reg <= 8'h00;
      long_dom_reg <= 1'b0;
    end else if (wired_bus == `DOMINANT_LEVEL) begin
      if (dom_cnt_reg != 8'hFF) begin
        dom_cnt_reg <= dom_cnt_reg + 8'h01;
      end
      long_dom_reg <= (dom_cnt_reg >= `MIN_DOM_CYC);
    end else begin
      dom_cnt_reg <= 8'h00;
      long_dom_reg <= 1'b0;
    end
  end

  // Dominant-to-recessive edge that closed a dominant bit over 1.5 us
  assign long_edge = long_dom_reg && (bus_prev_reg == `DOMINANT_LEVEL) &&
                     (wired_bus == `RECESSIVE_LEVEL);

  // One qualifier per bus fault detector
  genvar g;
  generate
    for (g = 0; g < `BUS_FLAG_COUNT; g = g + 1) begin : qual
      fault_qualifier u_qual (
        .clk_i(clk_i),
        .rst_n_i(rst_sync_reg),
        .bus_level_i(wired_bus),
        .long_edge_i(long_edge),
        .fault_raw_i(fault_sync_reg[g]),
        .fault_event_o(fault_event[g])
      );
    end
  endgenerate

  assign serial_set = serial_sync_reg && !serial_prev_reg;
  assign spi_wr_clear = reg_wr_i && (reg_addr_i == `ADDR_SPI_FAULT) &&
                        reg_wdata_i[`SPI_FAULT_BIT];
  assign bus_wr_clear = reg_wr_i && (reg_addr_i == `ADDR_BUS_FAULT);

  // Sticky flags; set beats clear so no event is lost in the clear cycle
  // Only the ones in the write data clear; zero bits leave their flag as it was.
  // Reserved write data bits have no flop behind them and are simply dropped.
  always @(posedge clk_i or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      serial_port_fault_flag <= 1'b0;
      bus_flags_reg <= 6'h00;
    end else begin
      serial_port_fault_flag <= serial_set |
                                (serial_port_fault_flag & ~spi_wr_clear);
      bus_flags_reg <= fault_event | (bus_flags_reg &
        ~({`BUS_FLAG_COUNT{bus_wr_clear}} & reg_wdata_i[`BUS_FLAG_COUNT-1:0]));
    end
  end

  // Register images; unused positions are hard zero
  assign spi_fault_interrupt_status_o = {serial_port_fault_flag, 7'h00};
  assign bus_fault_interrupt_status_o = {2'h0, bus_flags_reg};
  assign spi_or = |spi_fault_interrupt_status_o;
  assign bus_or = |bus_fault_interrupt_status_o;
  assign global_interrupt_o = {spi_or | bus_or, 2'h0, spi_or, bus_or, 3'h0};

  // Read data registered; unmapped addresses read zero
  // The address is sampled every edge, so a read needs no strobe of its own.
  // A read never clears anything; only a write of ones does.
  always @(posedge clk_i or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      reg_rdata_o <= `REG_RESET;
    end else begin
      case (reg_addr_i)
        `ADDR_GLOBAL_INT: reg_rdata_o <= global_interrupt_o;
        `ADDR_SPI_FAULT: reg_rdata_o <= spi_fault_interrupt_status_o;
        `ADDR_BUS_FAULT: reg_rdata_o <= bus_fault_interrupt_status_o;
        default: reg_rdata_o <= `REG_RESET;
      endcase
    end
  end
endmodule

// file: hw/fault_qualifier.v
// Qualifies one raw fault detector over four long dominant-to-recessive transitions
`timescale 1ns/1ps
`include "fault_flags_defs.vh"
module fault_qualifier (
  input wire clk_i,
  input wire rst_n_i,
  input wire bus_level_i,
  input wire long_edge_i,
  input wire fault_raw_i,
  output wire fault_event_o
);
  reg [`EDGE_CNT_W-1:0] edge_cnt_reg;
  reg [`EDGE_CNT_W-1:0] edge_cnt_next;

  // A fault that drops out restarts the count; it must persist through all edges
  always @* begin
    edge_cnt_next = edge_cnt_reg;
    if (!fault_raw_i) begin
      edge_cnt_next = {`EDGE_CNT_W{1'b0}};
    end else if (long_edge_i && edge_cnt_reg != `EDGE_QUAL) begin
      edge_cnt_next = edge_cnt_reg + 3'h1;
    end
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      edge_cnt_reg <= 3'h0;
    end else begin
      edge_cnt_reg <= edge_cnt_next;
    end
  end

  // Event stays asserted while qualified and the bus is recessive; flags re-set after a clear if fault remains
  assign fault_event_o = fault_raw_i && (edge_cnt_reg == `EDGE_QUAL) &&
                         (bus_level_i == `RECESSIVE_LEVEL);
endmodule

// file: inc/fault_flags_defs.vh
// Constants for the bus fault interrupt flag block
`ifndef FAULT_FLAGS_DEFS_VH
`define FAULT_FLAGS_DEFS_VH
`define ADDR_GLOBAL_INT 8'h50
`define ADDR_SPI_FAULT 8'h53
`define ADDR_BUS_FAULT 8'h54
`define SPI_FAULT_BIT 7
`define GLOBAL_SPI_BIT 4
`define GLOBAL_BUS_BIT 3
`define GLOBAL_ALL_BIT 7
`define BUS_SHORT_LINES_BIT 5
`define BUS_HIGH_BAT_BIT 4
`define BUS_LOW_GND_BIT 3
`define BUS_OPEN_BIT 2
`define BUS_GND_BIT 1
`define BUS_BAT_BIT 0
`define BUS_FLAG_COUNT 6
`define BUS_FLAG_MASK 8'h3F
`define REG_RESET 8'h00
`define RECESSIVE_LEVEL 1'b1
`define DOMINANT_LEVEL 1'b0
`define CLK_PERIOD_PS 8000
`define MIN_DOMINANT_PS 1500
`define MIN_DOMINANT_CYCLES ((`MIN_DOMINANT_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define MIN_DOM_PS_BUS 1500000
`define MIN_DOM_CYC (((`MIN_DOM_PS_BUS) + (`CLK_PERIOD_PS) - 1) / (`CLK_PERIOD_PS))
`define DOM_CNT_W 8
`define EDGE_QUAL 3'h4
`define EDGE_CNT_W 3
`endif
